// >>> logic/loop_code_pkg.sv
// ****************************************************************
// Shared constants for the loop code detector
// ****************************************************************
package loop_code_pkg;

  // Framer copies and register map, in register index units
  localparam int NUM_FRAMERS = 8;
  localparam int INDEX_WIDTH = 10;
  localparam logic [9:0] GROUP_BASE_INDEX = 10'h03c; // First copy
  localparam logic [9:0] GROUP_STRIDE_INDEX = 10'h080; // Step per copy
  localparam logic [6:0] CFG_INDEX = 7'h3c; // loop_code_length_config
  localparam logic [6:0] IRQ_INDEX = 7'h3d; // loop_code_irq_enable_status
  localparam logic [6:0] ACT_INDEX = 7'h3e; // loop_activate_pattern
  localparam logic [6:0] DEACT_INDEX = 7'h3f; // loop_deactivate_pattern

  // Length configuration fields
  localparam int CFG_RESERVED_BIT = 7;
  localparam int DEACT_LEN_SEL_HI = 3;
  localparam int DEACT_LEN_SEL_LO = 2;
  localparam int ACT_LEN_SEL_HI = 1;
  localparam int ACT_LEN_SEL_LO = 0;
  localparam logic [7:0] CFG_RW_MASK = 8'h8f; // Bits 6:4 unused

  // Enable/status fields
  localparam int ACT_CODE_PRESENT_INTERVAL = 7;
  localparam int DEACT_CODE_PRESENT_INTERVAL = 6;
  localparam int ACT_CHANGE_IRQ_EN = 5;
  localparam int DEACT_CHANGE_IRQ_EN = 4;
  localparam int ACT_CHANGE_IRQ_FLAG = 3;
  localparam int DEACT_CHANGE_IRQ_FLAG = 2;
  localparam int ACT_DETECT_STATE = 1;
  localparam int DEACT_DETECT_STATE = 0;

  // Reset values
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] PATTERN_RESET = 8'h00;
  localparam logic [1:0] IRQ_EN_RESET = 2'h0;

  // Code lengths: select 0 gives five bits
  localparam logic [3:0] MIN_CODE_LEN = 4'h5;
  localparam logic [3:0] GAP_RESET = 4'hf;
  // Intervals in a row needed to change the detect state
  localparam logic [1:0] QUAL_INTERVALS = 2'h2;

  // Presence interval
  localparam real INTERVAL_MS = 39.8;
  localparam real CLK_MHZ = 125.0;
  localparam int INTERVAL_CYCLES = $rtoi(INTERVAL_MS * 1.0e3 * CLK_MHZ);
  localparam int TIMER_WIDTH = 23;

  // APB
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

endpackage : loop_code_pkg

// >>> logic/loop_code_matcher.sv
`timescale 1ns/1ps
// ****************************************************************
// One code matcher: activate or deactivate code of one framer
// ****************************************************************
module loop_code_matcher (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] pattern, // First received bit in bit 7
  input wire logic [1:0] len_sel, // Code length select
  input wire logic rx_bit, // Received line bit
  input wire logic rx_valid, // Bit strobe
  input wire logic interval_tick, // End of presence interval
  output logic detect_state, // Debounced detect state
  output logic present_interval // Seen over last interval
);

  // Detect states, one-hot
  typedef enum logic [1:0] {
    st_absent = 2'b01,
    st_present = 2'b10
  } det_type;

  // All state of the matcher
  typedef struct packed {
    logic [7:0] hist; // Last eight bits, oldest at top
    logic [3:0] gap; // Bits since last pattern hit
    logic seen; // A hit occurred this interval
    logic missed; // A period passed with no hit
    logic present; // Result of last interval
    logic [1:0] qual_cnt; // Intervals in a row against state
    det_type det; // Detect state
  } match_type;

  match_type s;
  match_type next_s;
  logic [7:0] new_hist; // History with the new bit shifted in
  logic hit; // Window equals the pattern
  logic [3:0] code_len; // Code length in bits
  logic verdict; // Interval result
  logic qual_done; // Enough intervals against the state

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    next_s = s;
    code_len = loop_code_pkg::MIN_CODE_LEN + {2'b00, len_sel};
    new_hist = {s.hist[6:0], rx_bit};
    // Oldest bit meets bit 7 of the pattern
    hit = rx_valid && (new_hist == pattern);
    verdict = s.seen && !s.missed;
    qual_done = (s.qual_cnt == loop_code_pkg::QUAL_INTERVALS - 2'h1);
    if (rx_valid) begin
      next_s.hist = new_hist;
      if (hit) begin
        // Pattern recurs once per code period
        next_s.seen = 1'b1;
        next_s.gap = 4'h0;
      end else begin
        if (s.gap != loop_code_pkg::GAP_RESET) begin
          next_s.gap = s.gap + 4'h1;
        end
        // Next hit overdue: the stream lost the code
        if (s.gap + 4'h1 >= code_len) begin
          next_s.missed = 1'b1;
        end
      end
    end
    if (interval_tick) begin
      // Close the interval and open the next one
      next_s.present = verdict;
      next_s.seen = hit;
      next_s.missed = 1'b0;
      case (s.det)
        st_absent: begin
          // Needs two good intervals in a row before asserting
          if (!verdict) begin
            next_s.qual_cnt = 2'h0;
          end else if (qual_done) begin
            next_s.det = st_present;
            next_s.qual_cnt = 2'h0;
          end else begin
            next_s.qual_cnt = s.qual_cnt + 2'h1;
          end
        end
        st_present: begin
          // Same filter on loss, so a bit error does not drop it
          if (verdict) begin
            next_s.qual_cnt = 2'h0;
          end else if (qual_done) begin
            next_s.det = st_absent;
            next_s.qual_cnt = 2'h0;
          end else begin
            next_s.qual_cnt = s.qual_cnt + 2'h1;
          end
        end
        default: begin
          next_s.det = st_absent;
          next_s.qual_cnt = 2'h0;
        end
      endcase
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '{hist: 8'h00, gap: 4'hf, seen: 1'b0, missed: 1'b0,
             present: 1'b0, qual_cnt: 2'h0, det: st_absent};
    end else begin
      s <= next_s;
    end
  end

  assign detect_state = (s.det == st_present);
  assign present_interval = s.present;

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_present_on_tick: assert property (
    @(posedge pclk) disable iff (!presetn)
    $changed(present_interval) |-> $past(interval_tick))
    else $error("presence flag moved off an interval boundary");

  a_assert_needs_present: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(detect_state) |-> present_interval && $past(interval_tick))
    else $error("detect state rose without a good interval");

  a_deassert_needs_absent: assert property (
    @(posedge pclk) disable iff (!presetn)
    $fell(detect_state) |-> !present_interval && $past(interval_tick))
    else $error("detect state fell without an empty interval");

endmodule : loop_code_matcher

// >>> logic/loop_code_detector.sv
`timescale 1ns/1ps
// Overview of operation
// - Eight register copies, base 0x3c, step 0x80
// - Length select: 5, 6, 7, 8 bits
// - Presence flags report each 39.8 ms interval
// - Activate state change interrupts when enabled
// - Deactivate state change interrupts when enabled
// - Cause bits mark interrupting state changes
// - State bits show current detect state
// - Activate pattern matched, bit 7 first
// - Deactivate pattern matched, bit 7 first
module loop_code_detector #(
  parameter int unsigned INTERVAL_CYCLES = loop_code_pkg::INTERVAL_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] rx_bit, // Received bit per framer
  input wire logic [7:0] rx_valid, // Bit strobe per framer
  output logic irq_out_n // Interrupt, active low
);

  // ****************************************************************
  // State
  // ****************************************************************
  // Code pair index: 1 is activate, 0 is deactivate
  typedef struct packed {
    logic [7:0][7:0] cfg; // loop_code_length_config
    logic [7:0][1:0] irq_en; // Change interrupt enables
    logic [7:0][1:0] flag; // Change interrupt causes
    logic [7:0][7:0] act_pat; // loop_activate_pattern
    logic [7:0][7:0] deact_pat; // loop_deactivate_pattern
    logic [7:0][1:0] last_state; // Detect states one cycle ago
    logic [31:0] rdata; // Read data register
    logic [1:0] clr_mask; // Causes shown by the pending read
    logic [loop_code_pkg::TIMER_WIDTH-1:0] timer; // Interval timer
    logic tick; // Interval end pulse
    logic irq_n; // Registered interrupt pin
  } regs_type;

  regs_type s;
  regs_type next_s;

  // Bit 1 of each pair is activate, bit 0 deactivate
  logic [7:0][1:0] det_state; // Detect states from matchers
  logic [7:0][1:0] det_present; // Interval presence from matchers
  logic [9:0] index; // Register index from the byte address
  logic [2:0] sel_framer; // Addressed copy
  logic [6:0] sel_reg; // Index within the copy
  logic map_hit; // Address lands on a register
  logic setup_rd; // Setup cycle of a read
  logic done_wr; // Completing write
  logic done_rd; // Completing read

  // ****************************************************************
  // Matchers, one per code per framer
  // ****************************************************************
  for (genvar f = 0; f < loop_code_pkg::NUM_FRAMERS; f++) begin : g_framer
    loop_code_matcher u_act (
      .pclk(pclk),
      .presetn(presetn),
      .pattern(s.act_pat[f]),
      .len_sel({s.cfg[f][loop_code_pkg::ACT_LEN_SEL_HI],
                s.cfg[f][loop_code_pkg::ACT_LEN_SEL_LO]}),
      .rx_bit(rx_bit[f]),
      .rx_valid(rx_valid[f]),
      .interval_tick(s.tick),
      .detect_state(det_state[f][1]),
      .present_interval(det_present[f][1])
    );
    loop_code_matcher u_deact (
      .pclk(pclk),
      .presetn(presetn),
      .pattern(s.deact_pat[f]),
      .len_sel({s.cfg[f][loop_code_pkg::DEACT_LEN_SEL_HI],
                s.cfg[f][loop_code_pkg::DEACT_LEN_SEL_LO]}),
      .rx_bit(rx_bit[f]),
      .rx_valid(rx_valid[f]),
      .interval_tick(s.tick),
      .detect_state(det_state[f][0]),
      .present_interval(det_present[f][0])
    );
  end

  // ****************************************************************
  // Address decode
  // ****************************************************************
  // Each register index takes one word, so the byte address is 4x
  // Unmapped and misaligned words answer with an error and read zero
  always_comb begin
    index = paddr[11:2];
    sel_framer = index[9:7];
    sel_reg = index[6:0];
    // Copies sit at base plus multiples of the stride; misaligned misses
    map_hit = (paddr[1:0] == 2'b00) && (sel_reg >= loop_code_pkg::CFG_INDEX)
      && (sel_reg <= loop_code_pkg::DEACT_INDEX);
    setup_rd = psel && !penable && !pwrite;
    done_wr = psel && penable && pwrite && map_hit;
    done_rd = psel && penable && !pwrite && map_hit;
  end

  // No wait states: read data was registered in the setup cycle
  assign pready = 1'b1;
  assign pslverr = psel && penable && !map_hit;
  assign prdata = s.rdata;
  assign irq_out_n = s.irq_n;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic [7:0] status;
    logic [1:0] change;
    logic any_irq;
    status = 8'h00;
    change = 2'b00;
    any_irq = 1'b0;
    next_s = s;
    next_s.tick = 1'b0;
    // Shared interval timer for every matcher
    // Limitation: it free-runs from reset, so intervals are not aligned
    // to the code; a code that starts mid-interval may need a third
    // tick before its detect state asserts
    if (32'(s.timer) >= INTERVAL_CYCLES - 1) begin
      next_s.timer = '0;
      next_s.tick = 1'b1;
    end else begin
      next_s.timer = s.timer + 1'b1;
    end
    // Status word of the addressed copy
    status[loop_code_pkg::ACT_CODE_PRESENT_INTERVAL] =
      det_present[sel_framer][1];
    status[loop_code_pkg::DEACT_CODE_PRESENT_INTERVAL] =
      det_present[sel_framer][0];
    status[loop_code_pkg::ACT_CHANGE_IRQ_EN] = s.irq_en[sel_framer][1];
    status[loop_code_pkg::DEACT_CHANGE_IRQ_EN] = s.irq_en[sel_framer][0];
    status[loop_code_pkg::ACT_CHANGE_IRQ_FLAG] = s.flag[sel_framer][1];
    status[loop_code_pkg::DEACT_CHANGE_IRQ_FLAG] = s.flag[sel_framer][0];
    status[loop_code_pkg::ACT_DETECT_STATE] =
      det_state[sel_framer][1];
    status[loop_code_pkg::DEACT_DETECT_STATE] = det_state[sel_framer][0];
    // Read data captured in the setup cycle
    // The cause mask is taken with the data, so only what is returned
    // gets cleared at the access edge
    if (setup_rd) begin
      next_s.clr_mask = 2'b00;
      if (!map_hit) begin
        next_s.rdata = loop_code_pkg::READ_ZERO;
      end else begin
        case (sel_reg)
          loop_code_pkg::CFG_INDEX: begin
            // Unused bits read as zero
            next_s.rdata = {24'h00_0000,
              s.cfg[sel_framer] & loop_code_pkg::CFG_RW_MASK};
          end
          loop_code_pkg::IRQ_INDEX: begin
            next_s.rdata = {24'h00_0000, status};
            // Only causes that software actually sees get cleared
            next_s.clr_mask = s.flag[sel_framer];
          end
          loop_code_pkg::ACT_INDEX: begin
            next_s.rdata = {24'h00_0000, s.act_pat[sel_framer]};
          end
          default: begin
            next_s.rdata = {24'h00_0000, s.deact_pat[sel_framer]};
          end
        endcase
      end
    end
    // Register writes take effect at the completing edge
    if (done_wr && pstrb[0]) begin
      case (sel_reg)
        loop_code_pkg::CFG_INDEX: begin
          // Reserved bit stored as written; software keeps it zero
          next_s.cfg[sel_framer] = pwdata[7:0] & loop_code_pkg::CFG_RW_MASK;
        end
        loop_code_pkg::IRQ_INDEX: begin
          next_s.irq_en[sel_framer] = {
            pwdata[loop_code_pkg::ACT_CHANGE_IRQ_EN],
            pwdata[loop_code_pkg::DEACT_CHANGE_IRQ_EN]};
        end
        loop_code_pkg::ACT_INDEX: begin
          next_s.act_pat[sel_framer] = pwdata[7:0];
        end
        default: begin
          next_s.deact_pat[sel_framer] = pwdata[7:0];
        end
      endcase
    end
    // Cause bits: clear by status read, a new change wins
    // Trade-off: a change in the clearing cycle stays set, so a read
    // never hides an edge that software has not seen yet
    for (int f = 0; f < loop_code_pkg::NUM_FRAMERS; f++) begin
      next_s.last_state[f] = det_state[f];
      if (done_rd && (sel_reg == loop_code_pkg::IRQ_INDEX)
          && (sel_framer == 3'(f))) begin
        next_s.flag[f] = s.flag[f] & ~s.clr_mask;
      end
      // Either edge of the detect state, only while enabled
      change = (det_state[f] ^ s.last_state[f])
        & s.irq_en[f];
      next_s.flag[f] = next_s.flag[f] | change;
      any_irq = any_irq | (|(next_s.flag[f] & next_s.irq_en[f]));
    end
    // Pin stays low while any enabled cause remains
    next_s.irq_n = !any_irq;
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '{cfg: {8{loop_code_pkg::CFG_RESET}},
             irq_en: {8{loop_code_pkg::IRQ_EN_RESET}},
             flag: '0,
             act_pat: {8{loop_code_pkg::PATTERN_RESET}},
             deact_pat: {8{loop_code_pkg::PATTERN_RESET}},
             last_state: '0,
             rdata: loop_code_pkg::READ_ZERO,
             clr_mask: 2'b00,
             timer: '0,
             tick: 1'b0,
             irq_n: 1'b1};
    end else begin
      s <= next_s;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_irq_pin_level: assert property (
    @(posedge pclk) disable iff (!presetn)
    irq_out_n == !(|(s.flag & s.irq_en)))
    else $error("interrupt pin disagrees with enabled causes");

  a_unmapped_error: assert property (
    @(posedge pclk) disable iff (!presetn)
    psel && penable && (paddr[8:2] < loop_code_pkg::CFG_INDEX) |-> pslverr)
    else $error("unmapped access not answered with an error");

  a_write_act_pattern: assert property (
    @(posedge pclk) disable iff (!presetn)
    done_wr && pstrb[0] && (sel_reg == loop_code_pkg::ACT_INDEX)
    |=> s.act_pat[$past(sel_framer)] == $past(pwdata[7:0]))
    else $error("activate pattern write lost");

  // Register writes land at the completing edge
  a_write_deact_pattern: assert property (
    @(posedge pclk) disable iff (!presetn)
    done_wr && pstrb[0] && (sel_reg == loop_code_pkg::DEACT_INDEX)
    |=> s.deact_pat[$past(sel_framer)] == $past(pwdata[7:0]))
    else $error("deactivate pattern write lost");

  a_irq_enable_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    done_wr && pstrb[0] && (sel_reg == loop_code_pkg::IRQ_INDEX)
    |=> s.irq_en[$past(sel_framer)] ==
        {$past(pwdata[loop_code_pkg::ACT_CHANGE_IRQ_EN]),
         $past(pwdata[loop_code_pkg::DEACT_CHANGE_IRQ_EN])})
    else $error("interrupt enable write lost");

  // Without a new change, every cause that the read returned is gone
  a_status_read_clears: assert property (
    @(posedge pclk) disable iff (!presetn)
    done_rd && (sel_reg == loop_code_pkg::IRQ_INDEX)
    && (det_state[sel_framer] == s.last_state[sel_framer])
    |=> (s.flag[$past(sel_framer)] & $past(s.clr_mask)) == 2'b00)
    else $error("status read left a shown cause set");

  for (genvar f = 0; f < loop_code_pkg::NUM_FRAMERS; f++) begin : g_chk
    a_act_change_flag: assert property (
      @(posedge pclk) disable iff (!presetn)
      $changed(det_state[f][1]) && s.irq_en[f][1] |=> s.flag[f][1])
      else $error("activate change did not set its cause");

    a_deact_change_flag: assert property (
      @(posedge pclk) disable iff (!presetn)
      $changed(det_state[f][0]) && s.irq_en[f][0] |=> s.flag[f][0])
      else $error("deactivate change did not set its cause");

    a_flag_needs_enable: assert property (
      @(posedge pclk) disable iff (!presetn)
      $rose(s.flag[f][1]) |-> $past(s.irq_en[f][1]))
      else $error("cause set while its enable was off");

    a_deact_flag_enable: assert property (
      @(posedge pclk) disable iff (!presetn)
      $rose(s.flag[f][0]) |-> $past(s.irq_en[f][0]))
      else $error("deactivate cause set while disabled");
  end

endmodule : loop_code_detector

// >>> dv/rx_line_model.sv
`timescale 1ns/1ps
// ****************************************************************
// Receive line model: repeats one code on the selected framers
// ****************************************************************
module rx_line_model #(
  parameter int BIT_GAP = 4 // Clocks per received bit
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] run_mask, // Framers that carry the code
  input wire logic [7:0] seq, // Code, first bit in bit 7
  input wire logic [3:0] seq_len, // Bits in one repetition
  output logic [7:0] rx_bit,
  output logic [7:0] rx_valid
);
  int gap; // Clocks since last bit
  int pos; // Next code bit to send

  // Strobe one bit every BIT_GAP clocks; filler toggles between
  // strobes so a stale bit is never mistaken for a held line
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap <= 0;
      pos <= 0;
      rx_bit <= 8'h00;
      rx_valid <= 8'h00;
    end else begin
      if (gap == BIT_GAP - 1) begin
        gap <= 0;
        if (run_mask != 8'h00) begin
          // Oldest code bit goes first on the line
          rx_valid <= run_mask;
          rx_bit <= {8{seq[7 - pos]}};
          // Wraps even when a shorter code follows a longer one
          pos <= (pos >= int'(seq_len) - 1) ? 0 : pos + 1;
        end else begin
          rx_valid <= 8'h00;
          rx_bit <= ~rx_bit;
        end
      end else begin
        gap <= gap + 1;
        rx_valid <= 8'h00;
        rx_bit <= ~rx_bit;
      end
    end
  end
endmodule : rx_line_model

// >>> dv/loop_code_detector_tb_top.sv
`timescale 1ns/1ps
module loop_code_detector_tb_top;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] rx_bit;
  logic [7:0] rx_valid;
  logic irq_out_n;
  logic [7:0] run_mask = 8'h00; // Framers fed with code
  logic [7:0] seq = 8'h00;
  logic [3:0] seq_len = 4'h8;
  logic [31:0] v; // Last read word
  logic e; // Last error flag
  int n_fail = 0;
  int cmp_count = 0;

  // 125 MHz clock
  always #4 pclk = ~pclk;

  // Short interval keeps the run brief; 100 bits fit in one
  loop_code_detector #(.INTERVAL_CYCLES(400)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_bit(rx_bit), .rx_valid(rx_valid), .irq_out_n(irq_out_n)
  );

  rx_line_model #(.BIT_GAP(4)) line (
    .pclk(pclk), .presetn(presetn), .run_mask(run_mask), .seq(seq),
    .seq_len(seq_len), .rx_bit(rx_bit), .rx_valid(rx_valid)
  );

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen,
               exp);
    end
  endtask : check

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test

  // Byte address of register k in copy n
  function automatic logic [11:0] addr_of(input int n, input int k);
    return 12'((32'h0000_003c + 32'h0000_0080 * n + k) * 4);
  endfunction : addr_of

  // One APB transfer; request held until pready seen high
  task automatic xfer(input logic [11:0] a, input logic w,
                      input logic [7:0] d, input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    v = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input int n, input int k, input logic [7:0] d);
    xfer(addr_of(n, k), 1'b1, d, 4'hf);
  endtask : wr

  task automatic rd(input int n, input int k);
    xfer(addr_of(n, k), 1'b0, 8'h00, 4'h0);
  endtask : rd

  // Bounded wait for the interrupt pin to reach a level
  task automatic wait_irq(input logic lvl);
    for (int i = 0; i < 4000 && irq_out_n !== lvl; i++) begin
      @(posedge pclk);
      #1;
    end
  endtask : wait_irq

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset_map();
    for (int n = 0; n < 8; n += 7) begin
      for (int k = 0; k < 4; k++) begin
        rd(n, k);
        check(v, 32'h0000_0000);
      end
    end
    check({31'h0, irq_out_n}, 32'h0000_0001);
    wr(0, 0, 8'h7f); // Reserved top bit left at zero
    rd(0, 0);
    check(v, 32'h0000_000f);
    wr(0, 2, 8'h5a);
    xfer(addr_of(0, 2), 1'b1, 8'ha5, 4'h0); // No byte strobe
    rd(0, 2);
    check(v, 32'h0000_005a);
    xfer(12'h000, 1'b0, 8'h00, 4'h0); // Unmapped word
    check({v[31:1], e}, 32'h0000_0001);
    wr(0, 0, 8'h00);
    $display("test reset_map done");
  endtask : t_reset_map

  task automatic t_act_irq();
    wr(2, 0, 8'h03); // Eight bit activate code
    wr(2, 2, 8'h96);
    wr(2, 1, 8'h20);
    seq <= 8'h96;
    seq_len <= 4'h8;
    run_mask <= 8'h04;
    wait_irq(1'b0);
    check({31'h0, irq_out_n}, 32'h0000_0000);
    rd(2, 1);
    check(v, 32'h0000_00aa);
    rd(2, 1);
    check(v, 32'h0000_00a2);
    wait_irq(1'b1);
    check({31'h0, irq_out_n}, 32'h0000_0001);
    run_mask <= 8'h00; // Code removed from the line
    wait_irq(1'b0);
    rd(2, 1);
    check(v, 32'h0000_0028);
    rd(2, 1);
    check(v, 32'h0000_0020);
    wait_irq(1'b1);
    $display("test act_irq done");
  endtask : t_act_irq

  task automatic t_deact_masked();
    int lows;
    lows = 0;
    wr(5, 0, 8'h00); // Five bit codes
    wr(5, 3, 8'h08); // Repeating 00001
    wr(5, 1, 8'h00);
    seq <= 8'h08;
    seq_len <= 4'h5;
    run_mask <= 8'h20;
    repeat (2000) begin
      @(posedge pclk);
      #1;
      if (irq_out_n !== 1'b1) begin
        lows++;
      end
    end
    check(lows, 0);
    rd(5, 1);
    check(v, 32'h0000_0041);
    run_mask <= 8'h00;
    $display("test deact_masked done");
  endtask : t_deact_masked

  task automatic t_short_code();
    wr(7, 0, 8'h04); // Six bit deactivate length
    wr(7, 3, 8'h24); // Three bit 001 twice over
    wr(7, 1, 8'h10);
    seq <= 8'h24;
    seq_len <= 4'h3;
    run_mask <= 8'h80;
    wait_irq(1'b0);
    check({31'h0, irq_out_n}, 32'h0000_0000);
    rd(7, 1);
    check(v, 32'h0000_0055);
    rd(7, 1);
    check(v, 32'h0000_0051);
    run_mask <= 8'h00;
    $display("test short_code done");
  endtask : t_short_code

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_map();
    t_act_irq();
    t_deact_masked();
    t_short_code();
    end_of_test();
  end

  // Whole run needs roughly 4500 clocks
  initial begin
    #(40000 * 8);
    n_fail++;
    $display("watchdog expired at %0t", $time);
    end_of_test();
  end
endmodule : loop_code_detector_tb_top
